// ### inc/tcs_regs.svh
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
// host register offsets (word index on the user port)
`define TCS_OFF_CTRL 4'h0
`define TCS_OFF_CAL 4'h1
`define TCS_OFF_OCW 4'h2
`define TCS_OFF_OPW 4'h3
`define TCS_OFF_CFG 4'h4
`define TCS_OFF_SHUNT 4'h5
`define TCS_OFF_BUS 4'h6
`define TCS_OFF_CURR 4'h7
`define TCS_OFF_POWER 4'h8
`define TCS_OFF_ENERGY 4'h9
`define TCS_OFF_STATUS 4'hA
`define TCS_OFF_MASK 4'hB
// status bit positions
`define TCS_ST_DONE 0
`define TCS_ST_OC 1
`define TCS_ST_OP 2
`define TCS_ST_UNCAL 3
// reset values
`define TCS_CAL_RESET 16'h0000
`define TCS_CFG_RESET 16'h4127
`define TCS_OCW_RESET 16'h7FF8
`define TCS_OPW_RESET 16'h7FF8
// conversion config fields
`define TCS_CFG_AVG_LSB 9
`define TCS_CFG_MODE_LSB 0
// scaling: current = shunt*cal/2048, power = current*bus/20000
`define TCS_CUR_SHIFT 11
`define TCS_PWR_DIV 20000
// compare width
`define TCS_CMP_BITS 12
`endif

// ### inc/tcs_pkg.sv
package tcs_pkg;
  typedef logic signed [15:0] tcs_word_t;
  typedef enum logic [1:0] {TCS_OP_NONE, TCS_OP_WRITE, TCS_OP_READ} tcs_op_t;
  typedef enum logic [3:0] {
    TCS_R_CAL, TCS_R_OCW, TCS_R_OPW, TCS_R_CFG, TCS_R_SHUNT, TCS_R_BUS,
    TCS_R_CURR, TCS_R_POWER, TCS_R_ENERGY, TCS_R_STATUS
  } tcs_reg_t;
endpackage

// ### inc/tcs_link_if.sv
`timescale 1ns/1ps
// word-level register link: the host writes or reads one whole 2-byte word
interface tcs_link_if;
  import tcs_pkg::*;
  tcs_op_t op;
  tcs_reg_t sel;
  tcs_word_t wrWord;
  tcs_word_t rdWord;
  logic rdValid;
  modport device (input op, input sel, input wrWord, output rdWord, output rdValid);
  modport host (output op, output sel, output wrWord, input rdWord, input rdValid);
endinterface

// ### src/tcs_device.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_device
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  tcs_link_if.device link,
  input wire logic sampleValid,
  input wire logic signed [15:0] shuntSample,
  input wire logic signed [15:0] busSample,
  output logic resultStrobe,
  output logic ocWarn,
  output logic opWarn
);
  logic [15:0] calValue;
  logic [15:0] convCfg;
  tcs_word_t ocThresh;
  tcs_word_t opThresh;
  tcs_word_t shuntRes;
  tcs_word_t busRes;
  tcs_word_t currRes;
  tcs_word_t powerRes;
  tcs_word_t energyRes;
  logic [3:0] statusBits;
  logic [9:0] avgCount;
  logic signed [25:0] shuntAcc;
  logic signed [25:0] busAcc;
  logic signed [15:0] rdData;
  logic rdValid;
  logic armed;

  // averaging count decode from the config word, 1..1024 samples
  function automatic logic [9:0] avg_target(input logic [2:0] code);
    unique case (code)
      3'h0: avg_target = 10'h000;
      3'h1: avg_target = 10'h003;
      3'h2: avg_target = 10'h00F;
      3'h3: avg_target = 10'h03F;
      3'h4: avg_target = 10'h07F;
      3'h5: avg_target = 10'h0FF;
      3'h6: avg_target = 10'h1FF;
      3'h7: avg_target = 10'h3FF;
    endcase
  endfunction

  // arithmetic shift by the average exponent
  function automatic logic signed [15:0] avg_out(input logic signed [25:0] acc, input logic [2:0] code);
    logic signed [25:0] s;
    s = 26'sh0;
    unique case (code)
      3'h0: s = acc;
      3'h1: s = acc >>> 2;
      3'h2: s = acc >>> 4;
      3'h3: s = acc >>> 6;
      3'h4: s = acc >>> 7;
      3'h5: s = acc >>> 8;
      3'h6: s = acc >>> 9;
      3'h7: s = acc >>> 10;
    endcase
    avg_out = s[15:0];
  endfunction

  // decode of link requests
  wire isWrite = (link.op == TCS_OP_WRITE);
  wire isRead = (link.op == TCS_OP_READ);
  wire [2:0] avgCode = convCfg[`TCS_CFG_AVG_LSB +: 3];
  wire [2:0] modeCode = convCfg[`TCS_CFG_MODE_LSB +: 3];
  wire continuous = modeCode[2];
  wire shuntEn = modeCode[0];
  wire busEn = modeCode[1];
  // arm on the mode being written, so the write that enters triggered mode starts a run at once
  wire oneShotWrite = isWrite && (link.sel == TCS_R_CFG) && !link.wrWord[`TCS_CFG_MODE_LSB + 2];
  wire takeSample = sampleValid && (continuous || armed);
  wire lastSample = takeSample && (avgCount == avg_target(avgCode));
  wire signed [25:0] nextShuntAcc = (avgCount == 10'h000) ? 26'(shuntSample) : shuntAcc + 26'(shuntSample);
  wire signed [25:0] nextBusAcc = (avgCount == 10'h000) ? 26'(busSample) : busAcc + 26'(busSample);
  wire signed [15:0] avgShunt = avg_out(nextShuntAcc, avgCode);
  wire signed [15:0] avgBus = avg_out(nextBusAcc, avgCode);
  // current = shunt * cal / 2048, the 2048 absorbing the 0.00512 constant
  wire signed [32:0] currProd = 33'(avgShunt) * $signed({1'b0, calValue});
  wire signed [32:0] currFull = currProd >>> `TCS_CUR_SHIFT;
  wire signed [15:0] nextCurr = (calValue == 16'h0000) ? 16'sh0000 : currFull[15:0];
  // power LSB = 25 current LSB; bus LSB 1.25 mV so divide by 20000
  wire signed [32:0] pwrProd = 33'(nextCurr) * 33'(avgBus);
  wire signed [32:0] pwrFull = pwrProd / 33'(`TCS_PWR_DIV);
  wire signed [15:0] nextPower = pwrFull[15:0];
  wire signed [15:0] nextEnergy = energyRes + nextPower;
  // warning compare on upper 12 bits
  wire ocHit = $signed(currRes[15:4]) > $signed(ocThresh[15:4]);
  wire opHit = $signed(powerRes[15:4]) > $signed(opThresh[15:4]);

  // read data selection
  always_comb begin
    rdData = 16'sh0000;
    unique case (link.sel)
      TCS_R_CAL: rdData = calValue;
      TCS_R_OCW: rdData = ocThresh;
      TCS_R_OPW: rdData = opThresh;
      TCS_R_CFG: rdData = convCfg;
      TCS_R_SHUNT: rdData = shuntRes;
      TCS_R_BUS: rdData = busRes;
      TCS_R_CURR: rdData = currRes;
      TCS_R_POWER: rdData = powerRes;
      TCS_R_ENERGY: rdData = energyRes;
      TCS_R_STATUS: rdData = {12'h000, statusBits};
      default: rdData = 16'sh0000;
    endcase
  end

  // configuration words, defaults after every reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      calValue <= `TCS_CAL_RESET;
      convCfg <= `TCS_CFG_RESET;
      ocThresh <= `TCS_OCW_RESET;
      opThresh <= `TCS_OPW_RESET;
    end else if (isWrite) begin
      if (link.sel == TCS_R_CAL) calValue <= link.wrWord;
      if (link.sel == TCS_R_CFG) convCfg <= link.wrWord;
      if (link.sel == TCS_R_OCW) ocThresh <= link.wrWord;
      if (link.sel == TCS_R_OPW) opThresh <= link.wrWord;
    end
  end

  // averaging sequencer and one-shot arm
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avgCount <= 10'h000;
      shuntAcc <= 26'sh0;
      busAcc <= 26'sh0;
      armed <= 1'b0;
    end else begin
      if (oneShotWrite) begin
        armed <= 1'b1;
        avgCount <= 10'h000;
      end else if (takeSample) begin
        shuntAcc <= nextShuntAcc;
        busAcc <= nextBusAcc;
        avgCount <= lastSample ? 10'h000 : avgCount + 10'h001;
        if (lastSample) armed <= 1'b0;
      end
    end
  end

  // result words, refreshed only at the end of an averaging run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shuntRes <= 16'sh0000;
      busRes <= 16'sh0000;
      currRes <= 16'sh0000;
      powerRes <= 16'sh0000;
      energyRes <= 16'sh0000;
    end else if (lastSample) begin
      if (shuntEn) shuntRes <= avgShunt;
      if (busEn) busRes <= avgBus;
      currRes <= nextCurr;
      powerRes <= nextPower;
      energyRes <= nextEnergy;
    end
  end

  // sticky status, a read of the status word clears, set wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statusBits <= 4'h0;
    end else begin
      statusBits <= (isRead && link.sel == TCS_R_STATUS) ? 4'h0 : statusBits;
      if (lastSample) statusBits[`TCS_ST_DONE] <= 1'b1;
      if (ocHit) statusBits[`TCS_ST_OC] <= 1'b1;
      if (opHit) statusBits[`TCS_ST_OP] <= 1'b1;
      if (calValue == 16'h0000) statusBits[`TCS_ST_UNCAL] <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdValid <= 1'b0;
      link.rdWord <= 16'sh0000;
      resultStrobe <= 1'b0;
      ocWarn <= 1'b0;
      opWarn <= 1'b0;
    end else begin
      rdValid <= isRead;
      link.rdWord <= isRead ? rdData : 16'sh0000;
      resultStrobe <= lastSample;
      ocWarn <= ocHit;
      opWarn <= opHit;
    end
  end
  assign link.rdValid = rdValid;
endmodule

// ### src/tcs_host.sv
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_host
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  tcs_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq
);
  logic [15:0] ctrlReg;
  logic [3:0] statusReg;
  logic [3:0] maskReg;
  logic [15:0] lastWord;
  logic [3:0] nextStatus;

  // map of user offsets onto device words; ctrl/mask/status are local
  wire isLocal = (addr == `TCS_OFF_CTRL) || (addr == `TCS_OFF_STATUS) || (addr == `TCS_OFF_MASK);
  wire [3:0] devIdx = addr - `TCS_OFF_CAL;
  wire devAcc = !isLocal && (addr <= `TCS_OFF_ENERGY);
  wire devWritable = devAcc && (addr <= `TCS_OFF_CFG);
  wire [3:0] devEvents = link.rdValid ? link.rdWord[3:0] : 4'h0;
  wire statRead = rd && (addr == `TCS_OFF_STATUS);

  // drives the link one word at a time, whole 2-byte words only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.op <= TCS_OP_NONE;
      link.sel <= TCS_R_CAL;
      link.wrWord <= 16'sh0000;
    end else begin
      link.op <= (wr && devWritable) ? TCS_OP_WRITE : (rd && devAcc) ? TCS_OP_READ : TCS_OP_NONE;
      link.sel <= tcs_reg_t'(devIdx);
      link.wrWord <= wdata;
    end
  end

  // local control and mask words, defaults after every reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlReg <= 16'h0000;
      maskReg <= 4'h0;
    end else if (wr && addr == `TCS_OFF_CTRL) begin
      ctrlReg <= wdata;
    end else if (wr && addr == `TCS_OFF_MASK) begin
      maskReg <= wdata[3:0];
    end
  end

  // sticky status: link read completion and bit 1 of any returned link word, set wins over read-clear
  always_comb begin
    nextStatus = statRead ? 4'h0 : statusReg;
    if (link.rdValid) nextStatus[0] = 1'b1;
    if (devEvents[`TCS_ST_OC]) nextStatus[1] = 1'b1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statusReg <= 4'h0;
      lastWord <= 16'h0000;
      rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      statusReg <= nextStatus;
      if (link.rdValid) lastWord <= link.rdWord;
      irq <= |(nextStatus & maskReg);
      if (!rd) rdata <= 16'h0000;
      else if (addr == `TCS_OFF_CTRL) rdata <= ctrlReg;
      else if (addr == `TCS_OFF_STATUS) rdata <= {12'h000, statusReg};
      else if (addr == `TCS_OFF_MASK) rdata <= {12'h000, maskReg};
      else rdata <= lastWord;
    end
  end
endmodule

// ### test/tcs_link_assertions.sv
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_link_assertions
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input tcs_op_t op,
  input tcs_reg_t sel,
  input tcs_word_t wrWord,
  input tcs_word_t rdWord,
  input wire logic rdValid
);
  logic [15:0] shadow [0:3];
  logic calSeen;
  wire isRd = (op == TCS_OP_READ);
  wire isWr = (op == TCS_OP_WRITE);
  wire [15:0] expWord = shadow[sel[1:0]];
  // mirror of the writable settings, back to defaults on reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow[0] <= `TCS_CAL_RESET;
      shadow[1] <= `TCS_OCW_RESET;
      shadow[2] <= `TCS_OPW_RESET;
      shadow[3] <= `TCS_CFG_RESET;
      calSeen <= 1'b0;
    end else if (isWr && sel <= TCS_R_CFG) begin
      shadow[sel[1:0]] <= wrWord;
      calSeen <= calSeen | (sel == TCS_R_CAL);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence calWrite;
    isWr && sel == TCS_R_CAL;
  endsequence
  sequence calRead;
    isRd && sel == TCS_R_CAL;
  endsequence
  // link handshake and stored settings
  read_answer_a: assert property (isRd |=> rdValid)
    else $error("read not answered");
  answer_cause_a: assert property (rdValid |-> $past(isRd))
    else $error("answer without read");
  write_quiet_a: assert property (isWr |=> !rdValid)
    else $error("answer after write");
  write_target_a: assert property (isWr |-> sel <= TCS_R_CFG)
    else $error("write to result word");
  setting_readback_a: assert property (isRd && sel <= TCS_R_CFG |=> rdWord == $past(expWord))
    else $error("setting readback wrong");
  cal_update_a: assert property (calWrite ##1 calRead |=> rdWord == $past(wrWord, 2))
    else $error("new calibration not seen");
  uncal_zero_a: assert property (isRd && !calSeen && (sel == TCS_R_CURR || sel == TCS_R_POWER)
    |=> rdWord == 16'h0000)
    else $error("result before calibration");
  reset_idle_a: assert property ($fell(reset) |-> !isRd && !isWr)
    else $error("request at reset release");
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tb;
  import tcs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sampleValid = 1'b0;
  logic signed [15:0] shuntSample = 16'h0000;
  logic signed [15:0] busSample = 16'h0000;
  logic [15:0] rdata;
  logic irq;
  logic resultStrobe;
  logic ocWarn;
  logic opWarn;
  logic [15:0] v;
  int n_fail = 0;
  int num_checks = 0;
  tcs_link_if link();
  tcs_device tcs_device_inst (.clk(clk), .reset(reset), .link(link), .sampleValid(sampleValid),
    .shuntSample(shuntSample), .busSample(busSample), .resultStrobe(resultStrobe), .ocWarn(ocWarn), .opWarn(opWarn));
  tcs_host tcs_host_inst (.clk(clk), .reset(reset), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  tcs_link_assertions tcs_link_assertions_inst (.clk(clk), .reset(reset), .op(link.op), .sel(link.sel),
    .wrWord(link.wrWord), .rdWord(link.rdWord), .rdValid(link.rdValid));
  // free-running clock
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // write followed with no gap by a read of the same word
  task automatic wr_then_rd(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic rd_once(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // first read launches the link read, second one returns its word
  task automatic expect_reg(input logic [3:0] a, input logic [15:0] e);
    rd_once(a);
    repeat (3) @(posedge clk);
    rd_once(a);
    chk(v, e);
  endtask
  task automatic sample(input logic [15:0] sh, input logic [15:0] bu);
    @(posedge clk);
    shuntSample <= sh;
    busSample <= bu;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    // the strobe stands only one cycle, so look before each edge
    for (int i = 0; i <= 40; i++) begin
      if (i == 40) begin
        n_fail++;
        end_sim();
      end
      #1;
      if (resultStrobe === 1'b1) break;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one sample pair that does not wait for a result
  task automatic pulse(input logic [15:0] sh);
    @(posedge clk);
    shuntSample <= sh;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask
  task automatic t_defaults();
    expect_reg(`TCS_OFF_CAL, `TCS_CAL_RESET);
    expect_reg(`TCS_OFF_CFG, `TCS_CFG_RESET);
    expect_reg(`TCS_OFF_OCW, `TCS_OCW_RESET);
    expect_reg(`TCS_OFF_OPW, `TCS_OPW_RESET);
    sample(16'h1234, 16'h2710);
    expect_reg(`TCS_OFF_CURR, 16'h0000);
    expect_reg(`TCS_OFF_POWER, 16'h0000);
    expect_reg(`TCS_OFF_SHUNT, 16'h1234);
    expect_reg(`TCS_OFF_BUS, 16'h2710);
  endtask
  task automatic t_scaling();
    wr_reg(`TCS_OFF_CAL, 16'h0800);
    sample(16'h1000, 16'h2710);
    expect_reg(`TCS_OFF_CURR, 16'h1000);
    expect_reg(`TCS_OFF_POWER, 16'h0800);
    wr_then_rd(`TCS_OFF_CAL, 16'h0400);
    expect_reg(`TCS_OFF_CAL, 16'h0400);
    sample(16'hF000, 16'h2710);
    expect_reg(`TCS_OFF_SHUNT, 16'hF000);
    expect_reg(`TCS_OFF_CURR, 16'hF800);
    expect_reg(`TCS_OFF_POWER, 16'hFC00);
    expect_reg(`TCS_OFF_ENERGY, 16'h0400);
  endtask
  // lower four bits of threshold and result must not matter
  task automatic t_warn();
    wr_reg(`TCS_OFF_CAL, 16'h0800);
    wr_reg(`TCS_OFF_OCW, 16'h0108);
    wr_reg(`TCS_OFF_OPW, 16'h0010);
    sample(16'h010F, 16'h0000);
    chk({15'h0000, ocWarn}, 16'h0000);
    chk({15'h0000, opWarn}, 16'h0000);
    sample(16'h0110, 16'h4E20);
    chk({15'h0000, ocWarn}, 16'h0001);
    chk({15'h0000, opWarn}, 16'h0001);
  endtask
  // sticky status raises irq while unmasked, a status read clears it
  task automatic t_irq();
    rd_once(`TCS_OFF_STATUS);
    wr_reg(`TCS_OFF_MASK, 16'hFFFF);
    rd_once(`TCS_OFF_MASK);
    chk(v, 16'h000F);
    expect_reg(`TCS_OFF_CAL, 16'h0800);
    rd_once(4'hF);
    chk(v, 16'h0800);
    chk({15'h0000, irq}, 16'h0001);
    rd_once(`TCS_OFF_STATUS);
    chk({15'h0000, v[`TCS_ST_DONE]}, 16'h0001);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(`TCS_OFF_MASK, 16'h0000);
    expect_reg(`TCS_OFF_CAL, 16'h0800);
    chk({15'h0000, irq}, 16'h0000);
    rd_once(`TCS_OFF_STATUS);
    chk({15'h0000, v[`TCS_ST_DONE]}, 16'h0001);
  endtask
  // four averages: results hold until the last sample of the run
  task automatic t_average();
    wr_reg(`TCS_OFF_CFG, 16'h4327);
    pulse(16'h0100);
    pulse(16'h0200);
    pulse(16'h0300);
    expect_reg(`TCS_OFF_SHUNT, 16'h0110);
    sample(16'h0400, 16'h2710);
    expect_reg(`TCS_OFF_SHUNT, 16'h0280);
    expect_reg(`TCS_OFF_CURR, 16'h0280);
  endtask
  // triggered mode: one run per config write, none without it
  task automatic t_trigger();
    wr_reg(`TCS_OFF_CFG, 16'h0003);
    sample(16'h0200, 16'h2710);
    expect_reg(`TCS_OFF_SHUNT, 16'h0200);
    pulse(16'h0300);
    repeat (3) @(posedge clk);
    expect_reg(`TCS_OFF_SHUNT, 16'h0200);
    wr_reg(`TCS_OFF_CFG, 16'h0003);
    sample(16'h0400, 16'h2710);
    expect_reg(`TCS_OFF_SHUNT, 16'h0400);
  endtask
  task automatic t_reset();
    wr_reg(`TCS_OFF_CTRL, 16'h5A5A);
    rd_once(`TCS_OFF_CTRL);
    chk(v, 16'h5A5A);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    expect_reg(`TCS_OFF_CAL, `TCS_CAL_RESET);
    expect_reg(`TCS_OFF_OCW, `TCS_OCW_RESET);
    expect_reg(`TCS_OFF_CFG, `TCS_CFG_RESET);
    rd_once(`TCS_OFF_CTRL);
    chk(v, 16'h0000);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_scaling();
    t_warn();
    t_irq();
    t_average();
    t_trigger();
    t_reset();
    end_sim();
  end
endmodule
